// ==== clk_ctrl_pkg.sv ====
// constants for the system clock prescale and select block
// assumes a single 200 MHz sys_clk and fuse levels held stable at reset
package clk_ctrl_pkg;
   localparam logic [3:0] SRC_EXTERNAL = 4'h0;
   localparam logic [3:0] SRC_RC_CAL = 4'h2;
   localparam logic [1:0] SUT_FAST = 2'h0;
   localparam logic [1:0] SUT_MEDIUM = 2'h1;
   localparam logic [1:0] SUT_SLOW = 2'h2;
   localparam logic [1:0] ADDR_TRIM = 2'h0;
   localparam logic [1:0] ADDR_DIVCTL = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   localparam int CHG_BIT = 7;
   localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
   localparam logic [3:0] DIV_RESET_BY8 = 4'h3;
   localparam logic [3:0] DIV_MAX_CODE = 4'h8;
   localparam logic [2:0] CHG_WINDOW = 3'h4;
   localparam logic [7:0] WAKE_CYCLES = 8'h06;
   localparam logic [7:0] RESET_CYCLES = 8'h0e;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int DELAY_MEDIUM_US = 4100;
   localparam int DELAY_SLOW_US = 65000;
   localparam int DELAY_MEDIUM_CYC = DELAY_MEDIUM_US * 1000 / (CLK_PERIOD_PS / 1000);
   localparam int DELAY_SLOW_CYC = DELAY_SLOW_US * 1000 / (CLK_PERIOD_PS / 1000);
   typedef enum logic [1:0] {ST_RESET_WAIT, ST_WAKE_WAIT, ST_RUN, ST_SLEEP} start_state_t;
endpackage

// ==== clk_ctrl.sv ====
// system clock prescaler, clock output, start-up delay and rc trim register
// assumes synchronous fuse inputs and a one-cycle strobe register port
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module clk_ctrl
   import clk_ctrl_pkg::*;
#(
   parameter int MEDIUM_DELAY = DELAY_MEDIUM_CYC,
   parameter int SLOW_DELAY = DELAY_SLOW_CYC,
   parameter logic [7:0] FACTORY_TRIM = 8'h5a
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [3:0] clock_source_select_fuses,
   input wire logic [1:0] startup_delay_fuses,
   input wire logic clock_output_fuse,
   input wire logic divide_by_eight_fuse,
   input wire logic sleep_enter,
   input wire logic wake_event,
   input wire logic async_timer_external_clock_enable,
   input wire logic timer_osc_request,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic clock_output_pin,
   output logic clock_output_pin_oe,
   output logic io_clock_domain,
   output logic converter_clock_domain,
   output logic core_clock_domain,
   output logic program_memory_clock_domain,
   output logic use_external_input,
   output logic timer_osc_enable,
   output logic timer_osc_pin_external,
   output logic cpu_ready,
   output logic [7:0] rc_oscillator_trim
);
   logic [7:0] rc_trim_r;
   logic [3:0] div_r, div_nxt, div_act_r;
   logic chg_en_r;
   logic [2:0] chg_cnt_r;
   logic [7:0] cnt_r;
   logic [7:0] rdata_r;
   logic clk_div_r;
   logic [31:0] start_cnt_r;
   logic pend_r;
   start_state_t state_r;
   wire wr_trim = reg_wr && reg_addr == ADDR_TRIM;
   wire wr_div = reg_wr && reg_addr == ADDR_DIVCTL;
   wire unlock_wr = wr_div && reg_wdata == 8'h80;
   wire div_wr = wr_div && chg_en_r && !reg_wdata[CHG_BIT];
   wire [31:0] reset_extra = startup_delay_fuses == SUT_MEDIUM ? MEDIUM_DELAY :
      startup_delay_fuses == SUT_SLOW ? SLOW_DELAY : 0;
   wire [31:0] reset_total = reset_extra + 32'(RESET_CYCLES);
   wire [7:0] half = 8'((9'h1 << div_act_r) >> 1);
   wire div_one = div_act_r == 4'h0;
   wire at_edge = div_one || cnt_r == half - 8'h01;
   wire gated = clk_div_r && state_r == ST_RUN;
   wire [3:0] div_boot = divide_by_eight_fuse ? DIV_RESET_BY8 : DIV_RESET_PLAIN;

   assign div_nxt = reg_wdata[3:0];
   assign use_external_input = clock_source_select_fuses == SRC_EXTERNAL;
   assign timer_osc_enable = timer_osc_request &&
      clock_source_select_fuses == SRC_RC_CAL;
   assign timer_osc_pin_external = timer_osc_enable && async_timer_external_clock_enable;
   logic [3:0] domain_clk;
   for (genvar i = 0; i < 4; i++) begin : g_domain
      assign domain_clk[i] = gated;
   end
   assign io_clock_domain = domain_clk[0];
   assign converter_clock_domain = domain_clk[1];
   assign core_clock_domain = domain_clk[2];
   assign program_memory_clock_domain = domain_clk[3];
   assign clock_output_pin = div_one ? sys_clk : clk_div_r;
   assign clock_output_pin_oe = clock_output_fuse;
   assign cpu_ready = state_r == ST_RUN;
   assign rc_oscillator_trim = rc_trim_r;
   assign reg_rdata = rdata_r;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rc_trim_r <= FACTORY_TRIM;
      end else if (wr_trim) begin
         rc_trim_r <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         chg_en_r <= 1'b0;
         chg_cnt_r <= 3'h0;
      end else if (div_wr || (chg_en_r && chg_cnt_r == CHG_WINDOW - 3'h1)) begin
         chg_en_r <= 1'b0;
      end else if (unlock_wr && !chg_en_r) begin
         chg_en_r <= 1'b1;
         chg_cnt_r <= 3'h0;
      end else if (chg_en_r) begin
         chg_cnt_r <= chg_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div_r <= div_boot;
         pend_r <= 1'b1;
      end else if (div_wr) begin
         div_r <= div_nxt;
         pend_r <= 1'b1;
      end else if (pend_r && at_edge && !clk_div_r) begin
         pend_r <= 1'b0;
      end
   end

   // divider swaps rate only at the end of a low phase, so no short pulse
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div_act_r <= div_boot;
         cnt_r <= 8'h00;
         clk_div_r <= 1'b0;
      end else if (at_edge) begin
         cnt_r <= 8'h00;
         clk_div_r <= !clk_div_r;
         if (!clk_div_r && pend_r) begin
            div_act_r <= div_r > DIV_MAX_CODE ? DIV_MAX_CODE : div_r;
         end
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // start-up sequencing
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r <= ST_RESET_WAIT;
         start_cnt_r <= 32'h0;
      end else begin
         unique case (state_r)
            ST_RESET_WAIT: begin
               start_cnt_r <= start_cnt_r + 32'h1;
               if (start_cnt_r + 32'h1 >= reset_total) begin
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (sleep_enter) begin
                  state_r <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               start_cnt_r <= 32'h0;
               if (wake_event) begin
                  state_r <= ST_WAKE_WAIT;
               end
            end
            ST_WAKE_WAIT: begin
               start_cnt_r <= start_cnt_r + 32'h1;
               if (start_cnt_r + 32'h1 >= 32'(WAKE_CYCLES)) begin
                  state_r <= ST_RUN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_TRIM: rdata_r <= rc_trim_r;
            ADDR_DIVCTL: rdata_r <= {chg_en_r, 3'h0, div_r};
            ADDR_STATUS: rdata_r <= {6'h00, state_r};
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   // helper counters for the checks below
   logic [3:0] open_len_r;
   logic [7:0] phase_len_r;
   logic div_clk_q_r;
   logic [31:0] boot_len_r;

   always_ff @(posedge sys_clk) begin
      if (reset || !chg_en_r) begin
         open_len_r <= 4'h0;
      end else begin
         open_len_r <= open_len_r + 4'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      div_clk_q_r <= clk_div_r;
      if (reset || clk_div_r != div_clk_q_r) begin
         phase_len_r <= 8'h00;
      end else begin
         phase_len_r <= phase_len_r + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         boot_len_r <= 32'h0;
      end else if (state_r == ST_RESET_WAIT) begin
         boot_len_r <= boot_len_r + 32'h1;
      end
   end

   sequence s_unlock;
      unlock_wr && !chg_en_r;
   endsequence

   sequence s_quiet_window;
      !div_wr [*4];
   endsequence

   sequence s_wake_req;
      state_r == ST_SLEEP && wake_event;
   endsequence

   sequence s_wake_hold;
      !cpu_ready [*6] ##1 cpu_ready;
   endsequence

   sequence s_boot_done;
      state_r == ST_RESET_WAIT ##1 state_r == ST_RUN;
   endsequence

   // unlock window
   chk_unlock_clear: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(chg_en_r) |-> ##[1:4] !chg_en_r) else $error("change enable stuck");

   chk_unlock_only_zero: assert property (@(posedge sys_clk) disable iff (reset)
      (wr_div && reg_wdata[CHG_BIT] && reg_wdata[6:0] != 7'h0 && !chg_en_r) |=> !chg_en_r)
      else $error("change enable set by bad write");

   chk_unlock_set: assert property (@(posedge sys_clk) disable iff (reset)
      s_unlock |=> chg_en_r && chg_cnt_r == 3'h0) else $error("unlock not taken");

   chk_window_close: assert property (@(posedge sys_clk) disable iff (reset)
      s_unlock ##1 s_quiet_window |=> !chg_en_r) else $error("window left open");

   chk_window_len: assert property (@(posedge sys_clk) disable iff (reset)
      open_len_r <= 4'h4) else $error("window longer than four");

   chk_rewrite_keep: assert property (@(posedge sys_clk) disable iff (reset)
      (unlock_wr && chg_en_r && chg_cnt_r != CHG_WINDOW - 3'h1) |=>
      chg_en_r && chg_cnt_r == $past(chg_cnt_r) + 3'h1) else $error("rewrite moved window");

   chk_closed_write: assert property (@(posedge sys_clk) disable iff (reset)
      (wr_div && !chg_en_r) |=> $stable(div_r)) else $error("division changed while locked");

   // register port
   chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset)
      (reg_rd && reg_addr == ADDR_DIVCTL) |=> reg_rdata[6:4] == 3'h0)
      else $error("reserved bits read nonzero");

   chk_read_idle: assert property (@(posedge sys_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");

   chk_status_read: assert property (@(posedge sys_clk) disable iff (reset)
      (reg_rd && reg_addr == ADDR_STATUS) |=> reg_rdata[7:2] == 6'h00)
      else $error("status upper bits nonzero");

   chk_div_write: assert property (@(posedge sys_clk) disable iff (reset)
      div_wr |=> div_r == $past(reg_wdata[3:0])) else $error("division not stored");

   // reset values and trim
   chk_trim_reset: assert property (@(posedge sys_clk)
      $fell(reset) |-> rc_oscillator_trim == FACTORY_TRIM) else $error("trim not loaded");

   chk_div_reset: assert property (@(posedge sys_clk)
      $fell(reset) |-> div_r == div_boot && div_act_r == div_boot)
      else $error("division reset wrong");

   chk_trim_write: assert property (@(posedge sys_clk) disable iff (reset)
      wr_trim |=> rc_oscillator_trim == $past(reg_wdata)) else $error("trim not stored");

   chk_trim_hold: assert property (@(posedge sys_clk) disable iff (reset)
      !wr_trim |=> $stable(rc_oscillator_trim)) else $error("trim changed alone");

   // divider
   chk_div_limit: assert property (@(posedge sys_clk) disable iff (reset)
      div_act_r <= DIV_MAX_CODE) else $error("active divider out of range");

   chk_switch_edge: assert property (@(posedge sys_clk) disable iff (reset)
      $changed(div_act_r) |-> clk_div_r && cnt_r == 8'h00) else $error("rate swap mid phase");

   chk_phase_max: assert property (@(posedge sys_clk) disable iff (reset)
      phase_len_r <= 8'h7f) else $error("divided phase too long");

   chk_domains_same: assert property (@(posedge sys_clk) disable iff (reset)
      io_clock_domain == core_clock_domain) else $error("domains differ");

   chk_gate_idle: assert property (@(posedge sys_clk) disable iff (reset)
      !cpu_ready |-> !(io_clock_domain || converter_clock_domain || core_clock_domain ||
      program_memory_clock_domain)) else $error("domain clock while halted");

   // pins and sources
   chk_clock_out_en: assert property (@(posedge sys_clk)
      clock_output_pin_oe == clock_output_fuse) else $error("clock pin drive wrong");

   chk_timer_osc: assert property (@(posedge sys_clk) disable iff (reset)
      timer_osc_enable |-> clock_source_select_fuses == SRC_RC_CAL)
      else $error("timer osc with wrong source");

   chk_ext_timer: assert property (@(posedge sys_clk) disable iff (reset)
      timer_osc_pin_external |-> async_timer_external_clock_enable && timer_osc_enable)
      else $error("timer pin input without enable");

   chk_ext_select: assert property (@(posedge sys_clk) disable iff (reset)
      clock_source_select_fuses == SRC_EXTERNAL |-> use_external_input) else $error("no ext");

   // start-up sequencing
   chk_sleep_entry: assert property (@(posedge sys_clk) disable iff (reset)
      (cpu_ready && sleep_enter) |=> !cpu_ready) else $error("sleep not entered");

   chk_wake_time: assert property (@(posedge sys_clk) disable iff (reset)
      s_wake_req |=> s_wake_hold) else $error("wake delay wrong");

   chk_boot_time: assert property (@(posedge sys_clk) disable iff (reset)
      s_boot_done |-> boot_len_r == reset_total) else $error("reset delay wrong");
endmodule

// ==== clk_out_monitor.sv ====
// model of a circuit clocked from the clock output pin
// the pin toggles whether or not the output fuse is programmed; only its output enable follows the fuse
`timescale 1ns/10ps
module clk_out_monitor (
   input wire logic clock_output_pin,
   output real period_ns
);
   realtime last_edge;
   initial begin
      last_edge = 0;
      period_ns = 0;
   end
   // time between rising edges seen by the downstream circuit
   always @(posedge clock_output_pin) begin
      period_ns = $realtime - last_edge;
      last_edge = $realtime;
   end
endmodule

// ==== testbench.sv ====
// self-checking bench for the clock prescale and select block
// assumes the register port of clk_ctrl and a 200 MHz source clock
`timescale 1ns/10ps
module testbench;
   import clk_ctrl_pkg::*;
   localparam logic [7:0] TRIM_K = 8'h3c;
   logic sys_clk, reset, clock_output_fuse_f, div8_f, tx_en, tmr_req, reg_wr, reg_rd, sleep_in, wake_in;
   logic [3:0] src_f;
   logic [1:0] reg_addr, sut_f;
   logic [7:0] reg_wdata, reg_rdata, trim, d;
   logic pin, pin_oe, io_d, adc_d, core_d, pm_d, ext_in, tmr_en, tmr_ext, cpu_ready;
   int failures, checks_done, n;
   real per;
   clk_ctrl #(.MEDIUM_DELAY(20), .SLOW_DELAY(40), .FACTORY_TRIM(TRIM_K)) dut (
      .sys_clk(sys_clk), .reset(reset), .clock_source_select_fuses(src_f),
      .startup_delay_fuses(sut_f), .clock_output_fuse(clock_output_fuse_f),
      .divide_by_eight_fuse(div8_f), .sleep_enter(sleep_in), .wake_event(wake_in),
      .async_timer_external_clock_enable(tx_en), .timer_osc_request(tmr_req),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .clock_output_pin(pin), .clock_output_pin_oe(pin_oe),
      .io_clock_domain(io_d), .converter_clock_domain(adc_d), .core_clock_domain(core_d),
      .program_memory_clock_domain(pm_d), .use_external_input(ext_in),
      .timer_osc_enable(tmr_en), .timer_osc_pin_external(tmr_ext), .cpu_ready(cpu_ready),
      .rc_oscillator_trim(trim));
   clk_out_monitor mon (.clock_output_pin(pin), .period_ns(per));
   // steady source with no frequency steps
   initial begin
      sys_clk = 0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task cmp1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: flag %b want %b", $time, got, exp);
      end
   endtask
   task cmpt(input real got, input real exp);
      checks_done++;
      if (got != exp) begin
         failures++;
         $display("unexpected at %0t: period %f want %f", $time, got, exp);
      end
   endtask
   task wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1;
      @(posedge sys_clk);
      reg_wr <= 0;
   endtask
   task rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1 v = reg_rdata;
   endtask
   task wait_ready;
      n = 0;
      while (cpu_ready !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1 n++;
      end
   endtask
   task summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      reset = 1; src_f = SRC_EXTERNAL; clock_output_fuse_f = 1; div8_f = 0; tx_en = 1; tmr_req = 1;
      reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; sleep_in = 0; wake_in = 0;
      sut_f = SUT_FAST; failures = 0; checks_done = 0;
      repeat (5) @(posedge sys_clk);
      #1 cmp1(pin_oe, 1'b1);
      @(posedge sys_clk);
      reset <= 0;
      wait_ready;
      cmp1(n == 14, 1'b1);
      cmp1(ext_in, 1'b1);
      cmp1(tmr_en, 1'b0);
      rd(ADDR_TRIM, d); cmp8(d, TRIM_K);
      rd(ADDR_DIVCTL, d); cmp8(d, DIV_RESET_PLAIN);
      wr(ADDR_DIVCTL, 8'hf0); wr(ADDR_DIVCTL, 8'h03);
      rd(ADDR_DIVCTL, d); cmp8(d, 8'h00);
      for (int c = 0; c <= 8; c++) begin
         wr(ADDR_DIVCTL, 8'h80); wr(ADDR_DIVCTL, {4'h0, c[3:0]});
         rd(ADDR_DIVCTL, d); cmp8(d, {4'h0, c[3:0]});
         repeat (3 * (1 << c) + 4) @(posedge sys_clk);
         cmpt(per, 5.0 * (1 << c));
      end
      wr(ADDR_DIVCTL, 8'h80); repeat (5) @(posedge sys_clk); wr(ADDR_DIVCTL, 8'h01);
      rd(ADDR_DIVCTL, d); cmp8(d, 8'h08);
      wr(ADDR_DIVCTL, 8'h80); wr(ADDR_DIVCTL, 8'h80); wr(ADDR_DIVCTL, 8'h02);
      rd(ADDR_DIVCTL, d); cmp8(d, 8'h02);
      wr(ADDR_DIVCTL, 8'h80); wr(ADDR_DIVCTL, 8'h80); repeat (3) @(posedge sys_clk);
      wr(ADDR_DIVCTL, 8'h05); rd(ADDR_DIVCTL, d); cmp8(d, 8'h02);
      wr(ADDR_DIVCTL, 8'h80); wr(ADDR_DIVCTL, 8'h71); // nothing interrupts the pair
      rd(ADDR_DIVCTL, d); cmp8(d, 8'h01);
      wr(ADDR_TRIM, 8'h7f); rd(ADDR_TRIM, d); cmp8(d, 8'h7f);
      cmp8(trim, 8'h7f);
      rd(2'h3, d); cmp8(d, 8'h00);
      rd(ADDR_STATUS, d); cmp8(d, {6'h00, ST_RUN});
      @(posedge sys_clk); sleep_in <= 1;
      @(posedge sys_clk); sleep_in <= 0;
      #1 cmp1(cpu_ready, 1'b0);
      cmp1(io_d | adc_d | core_d | pm_d, 1'b0);
      @(posedge sys_clk); wake_in <= 1;
      @(posedge sys_clk); wake_in <= 0;
      wait_ready; cmp1(n == 6, 1'b1);
      @(posedge sys_clk);
      src_f <= SRC_RC_CAL; div8_f <= 1; sut_f <= SUT_MEDIUM; reset <= 1;
      repeat (6) @(posedge sys_clk);
      reset <= 0;
      wait_ready;
      cmp1(n == 34, 1'b1);
      cmpt(per, 40.0);
      cmp1(tmr_en, 1'b1);
      cmp1(tmr_ext, 1'b1);
      rd(ADDR_DIVCTL, d); cmp8(d, DIV_RESET_BY8);
      summarize;
   end
   initial begin
      #200000;
      failures++;
      summarize;
   end
endmodule
